// ### hdl/pps_pkg.sv
// Package for the peripheral pin select block: APB map, fields, resets.
// Assumes a 32-bit APB bus with word-aligned registers.
package pps_pkg;
  localparam int           PPS_AW            = 8;
  localparam logic [7:0]   PPS_STRAP_OFF     = 8'h00;
  localparam logic [7:0]   PPS_OWNER_OFF     = 8'h04;
  localparam logic [7:0]   PPS_GPIO_EN_OFF   = 8'h08;
  localparam logic [7:0]   PPS_GPIO_DIR_OFF  = 8'h0C;
  localparam logic [7:0]   PPS_ID_OFF        = 8'h10;
  // Strap status field positions
  localparam int           PPS_ST_CELL       = 0;
  localparam int           PPS_ST_PCI        = 1;
  localparam int           PPS_ST_SER2       = 2;
  localparam int           PPS_ST_AUTOINIT   = 3;
  // Ownership status field positions
  localparam int           PPS_OW_SP1        = 0;
  localparam int           PPS_OW_CELL       = 1;
  localparam int           PPS_OW_HOST       = 2;
  localparam int           PPS_OW_PCI        = 3;
  localparam int           PPS_OW_SP2        = 4;
  localparam int           PPS_OW_EEPROM     = 5;
  localparam int           PPS_OW_AUTOINIT   = 6;
  localparam int           PPS_OW_ALWAYS     = 7;
  localparam int           PPS_UGPIO_W       = 7;
  localparam logic [6:0]   PPS_GPIO_RST      = 7'h00;
  // Extra latching edges after reset release, covering the synchroniser
  localparam logic [1:0]   PPS_SETTLE_RST    = 2'h2;
  // Arbitrary identification value
  localparam logic [31:0]  PPS_ID_RST        = 32'h0000_5A01;
endpackage

// ### hdl/pps_top.sv
// Peripheral pin select: latches cell, host and auto-init straps just after reset release, steers pin
// ownership, and exposes straps, ownership and upper GPIO control on APB.
// Assumes straps are board-driven levels, asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pps_top
  import pps_pkg::*;
#(
  parameter int UGPIO_W = pps_pkg::PPS_UGPIO_W
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pps_pkg::PPS_AW-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       cell_port_select,
  input  wire logic                       ext_addr_strap_11,
  input  wire logic                       serial2_select,
  input  wire logic                       eeprom_autoinit_strap,
  input  wire logic                       host_bus_select_pin,
  output logic                            serial_port1_en,
  output logic                            cell_port_en,
  output logic                            cell_only_pins_oe,
  output logic                            serial1_only_pins_oe,
  output logic                            host_port_en,
  output logic                            pci_en,
  output logic                            pci_only_pins_oe,
  output logic                            serial_port2_en,
  output logic                            eeprom_if_en,
  output logic                            eeprom_autoinit_start,
  output logic                            always_on_en,
  output logic      [UGPIO_W-1:0]         upper_gpio_oe,
  output logic      [UGPIO_W-1:0]         upper_gpio_enable
);
  import pps_pkg::*;

  // Reset value of the GPIO control words limits the width
  if (UGPIO_W < 1 || UGPIO_W > PPS_UGPIO_W) begin : g_bad_width
    $error("UGPIO_W out of range");
  end

  typedef struct packed {
    logic [1:0]          cell_sync;
    logic [1:0]          host_sync;
    logic [1:0]          ser2_sync;
    logic [1:0]          ai_sync;
    logic                in_reset;
    logic [1:0]          settle;
    logic                cell_lat;
    logic                host_lat;
    logic                ai_lat;
    logic                ai_done;
    logic                ai_ran;
    logic [UGPIO_W-1:0]  gp_en;
    logic [UGPIO_W-1:0]  gp_dir;
    logic [31:0]         rdata;
    logic                ready;
    logic                slverr;
    logic                sp1;
    logic                cellp;
    logic                cell_oe;
    logic                sp1_oe;
    logic                host;
    logic                pci;
    logic                pci_oe;
    logic                sp2;
    logic                eep;
    logic                ai_start;
    logic                always_on;
    logic [UGPIO_W-1:0]  gp_oe;
    logic [UGPIO_W-1:0]  gp_ena;
  } pps_state_s;

  pps_state_s st_reg;
  pps_state_s st_next;

  logic cell_s;
  logic host_s;
  logic ser2_s;
  logic ai_s;
  logic access;
  logic sp2_now;

  // Only the second synchroniser stage is read
  assign cell_s  = st_reg.cell_sync[1];
  assign host_s  = st_reg.host_sync[1];
  assign ser2_s  = st_reg.ser2_sync[1];
  assign ai_s    = st_reg.ai_sync[1];
  assign access  = psel && penable && !st_reg.ready;
  assign sp2_now = !(st_reg.host_lat && !ser2_s);

  always_comb begin
    st_next = st_reg;
    st_next.cell_sync = {st_reg.cell_sync[0],
                         cell_port_select | ext_addr_strap_11};
    st_next.host_sync = {st_reg.host_sync[0], host_bus_select_pin};
    st_next.ser2_sync = {st_reg.ser2_sync[0], serial2_select};
    st_next.ai_sync   = {st_reg.ai_sync[0], eeprom_autoinit_strap};
    // Synchroniser is held in reset, so keep latching until the strap
    // levels have crossed both stages; then frozen until the next reset
    st_next.in_reset  = (st_reg.settle != 2'h0);
    if (st_reg.settle != 2'h0) begin
      st_next.settle = st_reg.settle - 2'h1;
    end
    if (st_reg.in_reset) begin
      st_next.cell_lat = cell_s;
      st_next.host_lat = host_s;
      st_next.ai_lat   = ai_s;
    end
    st_next.ai_start = 1'b0;
    if (!st_reg.in_reset && !st_reg.ai_done) begin
      st_next.ai_done  = 1'b1;
      st_next.ai_start = st_reg.host_lat && !ser2_s && st_reg.ai_lat;
      st_next.ai_ran   = st_next.ai_start;
    end
    st_next.sp1       = !st_reg.cell_lat;
    st_next.cellp     = st_reg.cell_lat;
    st_next.cell_oe   = st_reg.cell_lat;
    st_next.sp1_oe    = !st_reg.cell_lat;
    st_next.host      = !st_reg.host_lat;
    st_next.pci       = st_reg.host_lat;
    st_next.pci_oe    = st_reg.host_lat;
    st_next.sp2       = sp2_now;
    st_next.eep       = !sp2_now;
    st_next.always_on = 1'b1;
    st_next.gp_ena    = st_reg.host_lat ? '0 : st_reg.gp_en;
    st_next.gp_oe     = st_reg.host_lat ? '0
                                        : (st_reg.gp_en & st_reg.gp_dir);
    st_next.ready  = 1'b0;
    st_next.slverr = 1'b0;
    if (access) begin
      st_next.ready = 1'b1;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        PPS_STRAP_OFF: begin
          st_next.rdata[PPS_ST_CELL]     = st_reg.cell_lat;
          st_next.rdata[PPS_ST_PCI]      = st_reg.host_lat;
          st_next.rdata[PPS_ST_SER2]     = ser2_s;
          st_next.rdata[PPS_ST_AUTOINIT] = st_reg.ai_lat;
          st_next.slverr = pwrite;
        end
        PPS_OWNER_OFF: begin
          st_next.rdata[PPS_OW_SP1]      = st_reg.sp1;
          st_next.rdata[PPS_OW_CELL]     = st_reg.cellp;
          st_next.rdata[PPS_OW_HOST]     = st_reg.host;
          st_next.rdata[PPS_OW_PCI]      = st_reg.pci;
          st_next.rdata[PPS_OW_SP2]      = st_reg.sp2;
          st_next.rdata[PPS_OW_EEPROM]   = st_reg.eep;
          st_next.rdata[PPS_OW_AUTOINIT] = st_reg.ai_ran;
          st_next.rdata[PPS_OW_ALWAYS]   = st_reg.always_on;
          st_next.slverr = pwrite;
        end
        PPS_GPIO_EN_OFF: begin
          if (pwrite) begin
            st_next.gp_en = pwdata[UGPIO_W-1:0];
          end
          st_next.rdata[UGPIO_W-1:0] = st_reg.gp_en;
        end
        PPS_GPIO_DIR_OFF: begin
          if (pwrite) begin
            st_next.gp_dir = pwdata[UGPIO_W-1:0];
          end
          st_next.rdata[UGPIO_W-1:0] = st_reg.gp_dir;
        end
        PPS_ID_OFF: begin
          st_next.rdata  = PPS_ID_RST;
          st_next.slverr = pwrite;
        end
        default: begin
          st_next.slverr = 1'b1;
        end
      endcase
      if (pwrite) begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.in_reset <= 1'b1;
      st_reg.settle   <= PPS_SETTLE_RST;
      // Ownership rests in the all-straps-low default during reset, except always_on, which reset holds low
      st_reg.sp1      <= 1'b1;
      st_reg.sp1_oe   <= 1'b1;
      st_reg.host     <= 1'b1;
      st_reg.sp2      <= 1'b1;
      st_reg.gp_en    <= PPS_GPIO_RST[UGPIO_W-1:0];
      st_reg.gp_dir   <= PPS_GPIO_RST[UGPIO_W-1:0];
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata                = st_reg.rdata;
  assign pready                = st_reg.ready;
  assign pslverr               = st_reg.slverr;
  assign serial_port1_en       = st_reg.sp1;
  assign cell_port_en          = st_reg.cellp;
  assign cell_only_pins_oe     = st_reg.cell_oe;
  assign serial1_only_pins_oe  = st_reg.sp1_oe;
  assign host_port_en          = st_reg.host;
  assign pci_en                = st_reg.pci;
  assign pci_only_pins_oe      = st_reg.pci_oe;
  assign serial_port2_en       = st_reg.sp2;
  assign eeprom_if_en          = st_reg.eep;
  assign eeprom_autoinit_start = st_reg.ai_start;
  assign always_on_en          = st_reg.always_on;
  assign upper_gpio_oe         = st_reg.gp_oe;
  assign upper_gpio_enable     = st_reg.gp_ena;

  property p_sp2_excl;
    @(posedge pclk) disable iff (!presetn)
      !(serial_port2_en && eeprom_if_en);
  endproperty
  a_sp2_excl: assert property (p_sp2_excl)
    else $error("serial2 and eeprom both enabled");

  property p_cell_excl;
    @(posedge pclk) disable iff (!presetn)
      cell_port_en != serial_port1_en ##0 cell_only_pins_oe == cell_port_en;
  endproperty
  a_cell_excl: assert property (p_cell_excl)
    else $error("cell/serial1 ownership inconsistent");

  property p_host_pci;
    @(posedge pclk) disable iff (!presetn)
      host_port_en |-> !pci_only_pins_oe && !pci_en;
  endproperty
  a_host_pci: assert property (p_host_pci)
    else $error("PCI pins driven with host port");

  property p_gpio_pci;
    @(posedge pclk) disable iff (!presetn)
      pci_en |-> upper_gpio_oe == '0;
  endproperty
  a_gpio_pci: assert property (p_gpio_pci)
    else $error("upper gpio driven while PCI selected");

  property p_latch_hold;
    @(posedge pclk) disable iff (!presetn)
      !st_reg.in_reset |=> $stable(st_reg.cell_lat) && $stable(st_reg.host_lat);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched strap changed after reset");

  property p_sp2_dyn;
    @(posedge pclk) disable iff (!presetn)
      $rose(ser2_s) && !st_reg.in_reset |-> ##1 serial_port2_en;
  endproperty
  a_sp2_dyn: assert property (p_sp2_dyn)
    else $error("serial2 not enabled after select rose");

  property p_ai_once;
    @(posedge pclk) disable iff (!presetn)
      eeprom_autoinit_start |=> !eeprom_autoinit_start [*4];
  endproperty
  a_ai_once: assert property (p_ai_once)
    else $error("auto-init pulsed twice");

  property p_always;
    @(posedge pclk) disable iff (!presetn)
      !st_reg.in_reset |=> always_on_en;
  endproperty
  a_always: assert property (p_always)
    else $error("always-on group dropped");

  property p_pci_pins;
    @(posedge pclk) disable iff (!presetn)
      pci_only_pins_oe == pci_en && host_port_en != pci_en;
  endproperty
  a_pci_pins: assert property (p_pci_pins)
    else $error("host/PCI ownership inconsistent");

  property p_sp1_pins;
    @(posedge pclk) disable iff (!presetn)
      serial1_only_pins_oe == serial_port1_en;
  endproperty
  a_sp1_pins: assert property (p_sp1_pins)
    else $error("serial1 pins and ownership disagree");

  property p_ai_gate;
    @(posedge pclk) disable iff (!presetn)
      eeprom_autoinit_start |-> eeprom_if_en && pci_en;
  endproperty
  a_ai_gate: assert property (p_ai_gate)
    else $error("auto-init outside PCI with EEPROM");
endmodule // pps_top
`default_nettype wire

// ### sim/pps_straps.sv
// Board strap model for the peripheral pin select block.
// Assumes the bench picks the wanted levels through plain control inputs.
`timescale 1ns/1ps
`default_nettype none
module pps_straps (
  input  wire logic cell_want,
  input  wire logic ser2_want,
  input  wire logic ainit_want,
  input  wire logic host_want,
  output logic      cell_port_select,
  output logic      ext_addr_strap_11,
  output logic      serial2_select,
  output logic      eeprom_autoinit_strap,
  output logic      host_bus_select_pin
);
  // Firm levels only, never floating; both cell strap pins agree
  assign cell_port_select      = cell_want;
  assign ext_addr_strap_11     = cell_want;
  // Host select only moves while the bench holds reset
  assign host_bus_select_pin   = host_want;
  assign serial2_select        = ser2_want;
  assign eeprom_autoinit_strap = ainit_want;
endmodule // pps_straps
`default_nettype wire

// ### sim/tb_peripheral_pin_select.sv
// Self-checking bench for the peripheral pin select block.
// Assumes pps_pkg, pps_top and pps_straps are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_pin_select;
  import pps_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cell_want, ser2_want, ainit_want, cps, ea11, s2s, eas;
  logic        host_want, hbs;
  logic        sp1_en, cp_en, cp_oe, s1_oe, hp_en, pci_en, pci_oe;
  logic        sp2_en, ee_en, ee_go, aon_en;
  logic [6:0]  ug_oe, ug_en;
  int          mismatches, checks_done;
  int          ee_cnt = 0;

  pps_straps board (.cell_want(cell_want), .ser2_want(ser2_want),
    .ainit_want(ainit_want), .host_want(host_want),
    .host_bus_select_pin(hbs), .cell_port_select(cps),
    .ext_addr_strap_11(ea11), .serial2_select(s2s),
    .eeprom_autoinit_strap(eas));

  pps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_port_select(cps), .ext_addr_strap_11(ea11),
    .serial2_select(s2s), .eeprom_autoinit_strap(eas),
    .host_bus_select_pin(hbs),
    .serial_port1_en(sp1_en), .cell_port_en(cp_en),
    .cell_only_pins_oe(cp_oe), .serial1_only_pins_oe(s1_oe),
    .host_port_en(hp_en), .pci_en(pci_en), .pci_only_pins_oe(pci_oe),
    .serial_port2_en(sp2_en), .eeprom_if_en(ee_en),
    .eeprom_autoinit_start(ee_go), .always_on_en(aon_en),
    .upper_gpio_oe(ug_oe), .upper_gpio_enable(ug_en));

  always #2.5 pclk = ~pclk;

  // Auto-init pulses seen; an unknown level counts as a pulse too
  always @(posedge pclk) begin
    if (presetn === 1'b1 && ee_go !== 1'b0) ee_cnt <= ee_cnt + 1;
  end

  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("MISMATCH %0t bus answer timed out", $time);
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Straps cross the synchroniser, latch, then steer the outputs
  task automatic boot(input logic c, input logic s, input logic a,
                      input logic h);
    @(posedge pclk);
    cell_want <= c;
    ser2_want <= s;
    ainit_want <= a;
    host_want <= h;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    logic c, s, a, h, e;
    int ee_exp;
    {pclk, presetn, psel, penable, pwrite} = 5'h00;
    {cell_want, ser2_want, ainit_want, host_want} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checks_done = 0;
    ee_exp = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = i[0];
      s = i[1];
      h = i[2];
      a = i[0] ^ i[1];
      e = h & ~s;
      boot(c, s, a, h);
      if (e && a) ee_exp++;
      chk_bit(sp1_en, ~c);
      chk_bit(cp_oe, c);
      chk_bit(cp_en, c);
      chk_bit(s1_oe, ~c);
      chk_bit(hp_en, ~h);
      chk_bit(pci_en, h);
      chk_bit(pci_oe, h);
      chk_bit(sp2_en, ~e);
      chk_bit(ee_en, e);
      chk_bit(aon_en, 1'b1);
      chk_word(ee_cnt, ee_exp);
      apb(1'b0, PPS_STRAP_OFF, 32'h0);
      chk_word(rd, {28'h0, a, s, h, c});
      apb(1'b0, PPS_OWNER_OFF, 32'h0);
      chk_word(rd, {24'h0, 1'b1, e & a, e, ~e, h, ~h, c, ~c});
      // Upper GPIO only reaches the pins with PCI off
      apb(1'b1, PPS_GPIO_EN_OFF, 32'h7F);
      apb(1'b1, PPS_GPIO_DIR_OFF, 32'h0F);
      repeat (2) @(posedge pclk);
      chk_word({25'h0, ug_en}, h ? 32'h0 : 32'h7F);
      chk_word({25'h0, ug_oe}, h ? 32'h0 : 32'h0F);
      // Flip straps in operation: cell select frozen, serial2 live
      cell_want <= ~c;
      ser2_want <= ~s;
      repeat (4) @(posedge pclk);
      chk_bit(cp_en, c);
      chk_bit(pci_en, h);
      chk_bit(sp2_en, ~(h & s));
      chk_bit(ee_en, h & s);
      chk_word(ee_cnt, ee_exp);
      apb(1'b0, PPS_STRAP_OFF, 32'h0);
      chk_word(rd, {28'h0, a, ~s, h, c});
    end
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b0, PPS_GPIO_EN_OFF, 32'h0);
    chk_word(rd, {25'h0, PPS_GPIO_RST});
    apb(1'b1, PPS_GPIO_EN_OFF, 32'h55);
    apb(1'b1, PPS_GPIO_DIR_OFF, 32'h33);
    chk_bit(err, 1'b0);
    apb(1'b0, PPS_GPIO_DIR_OFF, 32'h0);
    chk_word(rd, 32'h33);
    chk_word({25'h0, ug_en}, 32'h55);
    chk_word({25'h0, ug_oe}, 32'h11);
    apb(1'b0, PPS_ID_OFF, 32'h0);
    chk_word(rd, PPS_ID_RST);
    apb(1'b0, 8'h14, 32'h0);
    chk_bit(err, 1'b1);
    apb(1'b1, PPS_STRAP_OFF, 32'hF);
    chk_bit(err, 1'b1);
    chk_word(ee_cnt, ee_exp);
    summarize();
  end
endmodule // tb_peripheral_pin_select
`default_nettype wire
